// File: logic/actind_top.sv
/*
 activity indicator logic: self-test progress reporting, processor
 activity lamps, network activity lamp pairs and transceiver supply
 control. assumes all inputs synchronous to mclk except the
 transceiver attachment lines, of which coll_in, data_in and tx_enable are synchronised here.
*/
// Contract
// (RQ1) step number to code word and lamps
// (RQ2) sequence done: interrupt, enter command wait
// (RQ3) four triggers start the diagnostic sequence
// (RQ4) idle check failure: error code, interrupt
// (RQ5) processor switches supply, reads it back
// (RQ6) supply trip: retry, report on failure
// (RQ7) onset lamp held 6 ms per event
// (RQ8) duration lamp follows event level
// (RQ9) data-out pair follows transmit enable
// (RQ10) collision pair ignores post-transmit heartbeat; only the onset lamp is blanked, the duration lamp follows it
// (RQ11) carrier pair: data in or collision
// (RQ12) send lamp while transmitting frame
// (RQ13) receive lamp for own-address frame
// (RQ14) monitor lamp while monitoring link
// (RQ15) download lamp from download to start
// (RQ16) boot-code lamp while running resident code
// (RQ17) quiescent lamp while idle polling
// (RQ18) idle-check lamp during background tests
// (RQ19) diagnostic-run lamp: others show codes
// (RQ20) loopback routes transmit data to receive
// (RQ21) fifteen lamps driven in total
// (RQ22) collision ends 200 ns after last edge
// (RQ23) 5.3 us blanking after transmit ends
// (RQ24) synchronised inputs, cycle counted hold
`timescale 1ns/1ns
`include "actind_cfg.svh"
module actind_top
   import actind_pkg::*;
#(
   parameter int ONSET_CYC = `ACTIND_ONSET_CYC,
   parameter int TAIL_CYC  = `ACTIND_TAIL_CYC,
   parameter int BLANK_CYC = `ACTIND_BLANK_CYC
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // diagnostic triggers
   input  wire logic       test_switch,
   input  wire logic       backplane_diag_write,
   input  wire logic       power_up_clear,
   input  wire logic       bus_wide_clear,
   // processor diagnostic reporting
   input  wire logic       step_wr,
   input  wire logic [7:0] step_num,
   input  wire logic       diag_done,
   input  wire logic       idle_fail,
   input  wire logic [7:0] idle_err_code,
   input  wire logic       host_irq_ack,
   // processor activity states
   input  wire logic       cpu_sending,
   input  wire logic       cpu_recv_own,
   input  wire logic       cpu_monitoring,
   input  wire logic       host_cmd_download,
   input  wire logic       host_cmd_start,
   input  wire logic       cpu_quiet,
   input  wire logic       cpu_idle_test,
   // transceiver supply
   input  wire logic       mau_power_set,
   input  wire logic       mau_power_clr,
   input  wire logic       mau_power_sense,
   input  wire logic       mau_power_trip,
   // transceiver attachment
   input  wire logic       tx_enable,
   input  wire logic       tx_data,
   input  wire logic       coll_in,
   input  wire logic       data_in,
   input  wire logic       loopback_en,
   // diagnostic outputs
   output logic [7:0]      diagnostic_code_word,
   output logic            host_irq,
   output logic            command_wait_phase,
   output logic            diag_start,
   output logic            mau_fault,
   output logic            mau_power_on,
   output logic            mau_power_ok,
   output logic            rx_data,
   // lamps
   output logic [7:0]      lamp_driver_latch,
   output logic            data_out_lamp_e,
   output logic            data_out_lamp_l,
   output logic            collision_lamp_e,
   output logic            collision_lamp_l,
   output logic            carrier_lamp_e,
   output logic            carrier_lamp_l,
   output logic            mau_power_lamp
);
   // ==========================================================
   // state
   typedef struct packed {
      actind_state_t state;
      logic [7:0]    code;
      logic [7:0]    lamps;
      logic          irq;
      logic          dl;
      logic          boot;
      logic          pwr;
      logic          retried;
      logic          fault;
      logic          ok;
      logic          rxd;
      logic          start;
      logic          tx_d;
      logic [15:0]   blank;
      logic [15:0]   ctail;
      logic [15:0]   dtail;
      logic          coll_d;
      logic          din_d;
      logic          wait_ph;
   } actind_top_t;
   actind_top_t st_r;
   actind_top_t st_nxt;

   logic coll_s;
   logic din_s;
   logic txen_s;
   logic coll_ev;
   logic car_ev;
   logic trig;

   // ==========================================================
   // attachment line synchronisers
   actind_sync u_sync_coll (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (coll_in),
      .q     (coll_s)
   ); // RQ24
   actind_sync u_sync_din (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (data_in),
      .q     (din_s)
   );
   actind_sync u_sync_txen (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (tx_enable),
      .q     (txen_s)
   );

   // events stretch to cover the gaps of the 10 MHz signalling
   assign coll_ev = (st_r.ctail != 16'h0000);          // RQ22
   assign car_ev = coll_ev || (st_r.dtail != 16'h0000); // RQ11
   assign trig = test_switch || backplane_diag_write ||
                 power_up_clear || bus_wide_clear;      // RQ3

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.start = trig;
      st_nxt.tx_d = txen_s;
      st_nxt.coll_d = coll_s;
      st_nxt.din_d = din_s;
      // collision: any edge reloads the tail timer
      if (coll_s != st_r.coll_d) begin
         st_nxt.ctail = 16'(TAIL_CYC);                 // RQ22
      end else if (st_r.ctail != 16'h0000) begin
         st_nxt.ctail = st_r.ctail - 16'h0001;
      end
      if (din_s != st_r.din_d) begin
         st_nxt.dtail = 16'(TAIL_CYC);
      end else if (st_r.dtail != 16'h0000) begin
         st_nxt.dtail = st_r.dtail - 16'h0001;
      end
      // heartbeat window opens as transmit ends
      if (st_r.tx_d && !txen_s) begin
         st_nxt.blank = 16'(BLANK_CYC);                // RQ23
      end else if (st_r.blank != 16'h0000) begin
         st_nxt.blank = st_r.blank - 16'h0001;
      end
      // loopback path, data in otherwise
      st_nxt.rxd = loopback_en ? tx_data : data_in;    // RQ20
      // supply control; one retry after a trip
      if (mau_power_trip && st_r.pwr) begin
         st_nxt.pwr = !st_r.retried;                   // RQ6
         st_nxt.fault = st_r.retried;                  // RQ6
         st_nxt.retried = 1'b1;
      end else if (mau_power_set) begin
         st_nxt.pwr = 1'b1;                            // RQ5
      end else if (mau_power_clr) begin
         st_nxt.pwr = 1'b0;                            // RQ5
         st_nxt.retried = 1'b0;
      end
      st_nxt.ok = mau_power_sense;                     // RQ5
      // firmware state lamps
      if (host_cmd_download) begin
         st_nxt.dl = 1'b1;                             // RQ15
      end else if (host_cmd_start) begin
         st_nxt.dl = 1'b0;                             // RQ15
         st_nxt.boot = 1'b0;                           // RQ16
      end
      // interrupt: set wins over acknowledge
      if (host_irq_ack) begin
         st_nxt.irq = 1'b0;
      end
      case (st_r.state)
         actind_st_diag: begin
            st_nxt.lamps[`ACTIND_L_DIAG] = 1'b1;       // RQ19
            if (step_wr) begin
               st_nxt.code = step_num;                 // RQ1
               st_nxt.lamps[6:0] = step_num[6:0];      // RQ1
            end
            if (diag_done) begin
               st_nxt.irq = 1'b1;                      // RQ2
               st_nxt.state = actind_st_wait;          // RQ2
            end
         end
         actind_st_wait, actind_st_run: begin
            if (host_cmd_start) begin
               st_nxt.state = actind_st_run;
            end
            if (idle_fail) begin
               st_nxt.code = idle_err_code;            // RQ4
               st_nxt.irq = 1'b1;                      // RQ4
            end
         end
         default: begin
            st_nxt.state = actind_st_diag;
         end
      endcase
      // normal lamp meanings from the very cycle the sequence ends, so the
      // diagnostic-run lamp never stands lit beside the wait phase
      if (st_nxt.state != actind_st_diag) begin
         st_nxt.lamps[`ACTIND_L_DIAG] = 1'b0;          // RQ19
         st_nxt.lamps[`ACTIND_L_SEND] = cpu_sending;   // RQ12
         st_nxt.lamps[`ACTIND_L_RECV] = cpu_recv_own;  // RQ13
         st_nxt.lamps[`ACTIND_L_MON] = cpu_monitoring; // RQ14
         st_nxt.lamps[`ACTIND_L_DNLD] = st_nxt.dl;     // RQ15
         st_nxt.lamps[`ACTIND_L_BOOT] = st_nxt.boot;   // RQ16
         st_nxt.lamps[`ACTIND_L_QUIET] = cpu_quiet;    // RQ17
         st_nxt.lamps[`ACTIND_L_IDLE] = cpu_idle_test; // RQ18
      end
      // any trigger restarts the sequence with all eight processor lamps lit
      if (trig) begin
         st_nxt.state = actind_st_diag;                // RQ3
         st_nxt.lamps = `ACTIND_LAMPS_RST;
         st_nxt.boot = 1'b1;
         st_nxt.dl = 1'b0;
         st_nxt.pwr = 1'b0;
      end
      // registered so the phase output comes straight from a flip-flop
      st_nxt.wait_ph = (st_nxt.state != actind_st_diag);  // RQ2
   end

   // ==========================================================
   // state register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.state <= actind_st_diag;
         st_r.lamps <= `ACTIND_LAMPS_RST;
         st_r.code <= `ACTIND_CODE_RST;
         st_r.boot <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // network lamp pairs, seven lamps with the supply lamp (RQ21)
   actind_pair #(.HOLD_CYC(ONSET_CYC)) u_pair_do (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .ev         (st_r.tx_d),
      .onset_ok   (1'b1),
      .lamp_onset (data_out_lamp_e),
      .lamp_dur   (data_out_lamp_l)
   ); // RQ9
   actind_pair #(.HOLD_CYC(ONSET_CYC)) u_pair_cl (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .ev         (coll_ev),
      .onset_ok   (st_r.blank == 16'h0000 && !st_r.tx_d),
      .lamp_onset (collision_lamp_e),
      .lamp_dur   (collision_lamp_l)
   ); // RQ10
   actind_pair #(.HOLD_CYC(ONSET_CYC)) u_pair_cr (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .ev         (car_ev),
      .onset_ok   (st_r.blank == 16'h0000 || st_r.dtail != 16'h0000),
      .lamp_onset (carrier_lamp_e),
      .lamp_dur   (carrier_lamp_l)
   ); // RQ11

   // ==========================================================
   // outputs straight from flip-flops
   assign diagnostic_code_word = st_r.code;
   assign lamp_driver_latch = st_r.lamps;          // RQ21
   assign host_irq = st_r.irq;
   assign command_wait_phase = st_r.wait_ph;
   assign diag_start = st_r.start;
   assign mau_fault = st_r.fault;
   assign mau_power_on = st_r.pwr;
   assign mau_power_ok = st_r.ok;
   assign mau_power_lamp = st_r.ok;
   assign rx_data = st_r.rxd;
endmodule // actind_top

// File: pkg/actind_cfg.svh
/*
 activity indicator constants: timing figures, lamp bit positions and
 reset values. assumes a 125 MHz system clock.
*/
`ifndef ACTIND_CFG_SVH
`define ACTIND_CFG_SVH
// ==========================================================
// clock and timing
`define ACTIND_CLK_MHZ        125
`define ACTIND_ONSET_MS       6
`define ACTIND_ONSET_CYC      (`ACTIND_ONSET_MS * `ACTIND_CLK_MHZ * 1000)
`define ACTIND_TAIL_NS        200
`define ACTIND_TAIL_CYC       ((`ACTIND_TAIL_NS * `ACTIND_CLK_MHZ) / 1000)
`define ACTIND_BLANK_NS       5300
`define ACTIND_BLANK_CYC      ((`ACTIND_BLANK_NS * `ACTIND_CLK_MHZ) / 1000)
// ==========================================================
// processor lamp bit positions
`define ACTIND_L_SEND         0
`define ACTIND_L_RECV         1
`define ACTIND_L_MON          2
`define ACTIND_L_DNLD         3
`define ACTIND_L_BOOT         4
`define ACTIND_L_QUIET        5
`define ACTIND_L_IDLE         6
`define ACTIND_L_DIAG         7
// ==========================================================
// reset values
`define ACTIND_LAMPS_RST      8'hff
`define ACTIND_CODE_RST       8'h00
`define ACTIND_STEP_LAST      8'h07
`endif

// File: pkg/actind_pkg.sv
/*
 activity indicator types. assumes actind_cfg.svh for the figures.
*/
package actind_pkg;
   // ==========================================================
   // diagnostic sequencer states, gray along the usual path
   typedef enum logic [1:0] {
      actind_st_diag  = 2'b00,
      actind_st_wait  = 2'b01,
      actind_st_run   = 2'b11
   } actind_state_t;
endpackage

// File: logic/actind_sync.sv
/*
 two flip-flop synchroniser for one level.
 assumes the input may change at any time relative to mclk.
*/
`timescale 1ns/1ns
module actind_sync (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // level
   input  wire logic d,
   output logic      q
);
   typedef struct packed {
      logic s1;
      logic s2;
   } actind_sync_t;
   actind_sync_t st_r;
   actind_sync_t st_nxt;

   // first stage feeds only the second
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule // actind_sync

// File: logic/actind_pair.sv
/*
 one network lamp pair: onset lamp stretched to a fixed hold time,
 duration lamp follows the event level. assumes a synchronous event
 level and a one-cycle onset qualifier.
*/
`timescale 1ns/1ns
`include "actind_cfg.svh"
module actind_pair
   import actind_pkg::*;
#(
   parameter int HOLD_CYC = `ACTIND_ONSET_CYC
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // event
   input  wire logic ev,
   input  wire logic onset_ok,
   // lamps
   output logic      lamp_onset,
   output logic      lamp_dur
);
   typedef struct packed {
      logic        ev_d;
      logic [23:0] cnt;
      logic        on;
      logic        dur;
   } actind_pair_t;
   actind_pair_t st_r;
   actind_pair_t st_nxt;

   // new onset restarts the hold count
   always_comb begin
      st_nxt = st_r;
      st_nxt.ev_d = ev;
      st_nxt.dur = ev;                               // RQ8
      if (ev && !st_r.ev_d && onset_ok) begin
         st_nxt.cnt = 24'(HOLD_CYC - 1);             // RQ24
         st_nxt.on = 1'b1;                           // RQ7
      end else if (st_r.cnt != 24'h000000) begin
         st_nxt.cnt = st_r.cnt - 24'h000001;
      end else begin
         st_nxt.on = 1'b0;                           // RQ7
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lamp_onset = st_r.on;
   assign lamp_dur = st_r.dur;
endmodule // actind_pair

// File: test/actind_mau_model.sv
/*
 transceiver model: heartbeat burst after each transmission, collision
 and receive bursts on request, supply sense. assumes bench requests
 change just after mclk rises.
*/
`timescale 1ns/1ns
module actind_mau_model (
   // clock
   input  wire logic mclk,
   // device side
   input  wire logic mau_power_on,
   input  wire logic tx_enable,
   // bench requests
   input  wire logic coll_req,
   input  wire logic data_req,
   // attachment lines
   output logic      coll_in,
   output logic      data_in,
   output logic      mau_power_sense
);
   logic tx_d = 1'b0;
   int   hb   = 0;
   // ==========================================================
   // lines idle quiet: no transitions outside a burst
   initial {coll_in, data_in, mau_power_sense} = 3'h0;
   // heartbeat toggles a few cycles after every transmission, so the
   // blanking window is always exercised
   always @(posedge mclk) begin
      tx_d <= tx_enable;
      if (tx_d && !tx_enable) hb <= 10;
      else if (hb > 0) hb <= hb - 1;
      coll_in <= (coll_req || (hb > 0 && hb < 9)) ? !coll_in : 1'b0;
      data_in <= data_req ? !data_in : 1'b0;
      mau_power_sense <= mau_power_on;
   end
endmodule // actind_mau_model

// File: test/actind_top_asserts.sv
/*
 checker for the activity indicator: diagnostic reporting and network
 lamp pairs. assumes the bind at the foot into actind_top.
*/
`timescale 1ns/1ns
module actind_asserts #(
   parameter int ONSET_CYC = 50
) (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   // triggers and processor reporting
   input wire logic       test_switch,
   input wire logic       backplane_diag_write,
   input wire logic       power_up_clear,
   input wire logic       bus_wide_clear,
   input wire logic       step_wr,
   input wire logic [7:0] step_num,
   input wire logic       diag_done,
   input wire logic       idle_fail,
   input wire logic [7:0] idle_err_code,
   // attachment lines
   input wire logic       tx_enable,
   input wire logic       coll_in,
   input wire logic       data_in,
   // outputs watched
   input wire logic [7:0] diagnostic_code_word,
   input wire logic       host_irq,
   input wire logic       command_wait_phase,
   input wire logic       diag_start,
   input wire logic [7:0] lamp_driver_latch,
   input wire logic       data_out_lamp_e,
   input wire logic       data_out_lamp_l,
   input wire logic       collision_lamp_e,
   input wire logic       collision_lamp_l,
   input wire logic       carrier_lamp_l
);
   logic trig;
   int   on_cnt;
   // ==========================================================
   // any restart source; it overrides the state, lamp and supply requests
   assign trig = test_switch | backplane_diag_write | power_up_clear |
                 bus_wide_clear;
   // cycles the onset lamp has stood, so a short hold is caught
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) on_cnt <= 0;
      else on_cnt <= data_out_lamp_e ? on_cnt + 1 : 0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // properties
   trig_start_a: assert property (trig |=> diag_start &&
      !command_wait_phase) else $error("restart not taken");
   step_code_a: assert property (step_wr && !command_wait_phase &&
      !trig |=> diagnostic_code_word == $past(step_num) &&
      lamp_driver_latch == {1'b1, $past(step_num[6:0])})
      else $error("step number not shown");
   done_irq_a: assert property (diag_done && !command_wait_phase &&
      !trig |=> host_irq && command_wait_phase && !lamp_driver_latch[7])
      else $error("sequence end not reported");
   idle_err_a: assert property (idle_fail && command_wait_phase &&
      !trig |=> host_irq && diagnostic_code_word == $past(idle_err_code))
      else $error("idle failure not reported");
   onset_hold_a: assert property ($fell(data_out_lamp_e) |->
      on_cnt >= ONSET_CYC) else $error("onset lamp hold short");
   dur_rise_a: assert property ($rose(tx_enable) |->
      ##[2:5] data_out_lamp_l) else $error("data out lamp late");
   coll_blank_a: assert property ($fell(tx_enable) |->
      ##2 (!$rose(collision_lamp_e)) [*8])
      else $error("heartbeat lit collision onset");
   coll_dur_a: assert property ($rose(coll_in) |->
      ##[2:6] collision_lamp_l) else $error("collision lamp late");
   carr_dur_a: assert property ($rose(data_in) |->
      ##[2:6] carrier_lamp_l) else $error("carrier lamp late");
   // main scenarios reached
   cover property ($rose(collision_lamp_e));
   cover property (diag_done && !command_wait_phase);
   cover property ($fell(data_out_lamp_e));
endmodule // actind_asserts
bind actind_top actind_asserts #(.ONSET_CYC(ONSET_CYC)) actind_asserts_i (.*);

// File: test/tb_actind_top.sv
/*
 bench for the activity indicator: self test, processor lamps, supply,
 lamp pairs and loopback. assumes shortened hold and blank counts and
 the transceiver model beside the block.
*/
`timescale 1ns/1ns
module tb_actind_top;
   localparam int HOLD = 50;
   logic mclk = '0, rst_b = '0, test_switch = '0, backplane_diag_write = '0;
   logic power_up_clear = '0, bus_wide_clear = '0, step_wr = '0;
   logic diag_done = '0, idle_fail = '0, host_irq_ack = '0, tx_data = '0;
   logic cpu_sending = '0, cpu_recv_own = '0, cpu_monitoring = '0;
   logic host_cmd_download = '0, host_cmd_start = '0, cpu_quiet = '0;
   logic cpu_idle_test = '0, mau_power_set = '0, mau_power_clr = '0;
   logic mau_power_trip = '0, tx_enable = '0, loopback_en = '0;
   logic coll_req = '0, data_req = '0, mau_power_sense, coll_in, data_in;
   logic [7:0] step_num = '0, idle_err_code = '0;
   logic [7:0] diagnostic_code_word, lamp_driver_latch;
   logic host_irq, command_wait_phase, diag_start, mau_fault, rx_data;
   logic mau_power_on, mau_power_ok, mau_power_lamp, data_out_lamp_e;
   logic data_out_lamp_l, collision_lamp_e, collision_lamp_l;
   logic carrier_lamp_e, carrier_lamp_l;
   int   err_count = 0, compares = 0;
   // ==========================================================
   // block and transceiver
   actind_top #(.ONSET_CYC(HOLD), .BLANK_CYC(20)) actind_top_i (.*);
   actind_mau_model actind_mau_model_i (.*);
   initial forever #4 mclk = ~mclk;
   // ==========================================================
   // helpers: inputs move 1 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic ack;
      host_irq_ack = 1'b1;
      cyc(1);
      host_irq_ack = 1'b0;
      chk(8'(host_irq), 8'h00);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_self(input int i);
      {test_switch, backplane_diag_write, power_up_clear,
       bus_wide_clear} = 4'(1 << i);
      cyc(1);
      {test_switch, backplane_diag_write, power_up_clear,
       bus_wide_clear} = 4'h0;
      chk(8'({diag_start, command_wait_phase}), 8'h02);
      step_wr = 1'b1;
      step_num = 8'(8'h40 + i);
      cyc(1);
      step_wr = 1'b0;
      chk(diagnostic_code_word, step_num);
      chk(lamp_driver_latch, 8'h80 | step_num);
      diag_done = 1'b1;
      cyc(1);
      diag_done = 1'b0;
      chk(8'({host_irq, command_wait_phase, lamp_driver_latch[7],
              lamp_driver_latch[4]}), 8'h0d);
      ack();
   endtask
   task automatic t_cpu;
      int pos[5] = '{0, 1, 2, 5, 6};
      for (int i = 0; i < 5; i++) begin
         {cpu_idle_test, cpu_quiet, cpu_monitoring, cpu_recv_own,
          cpu_sending} = 5'(1 << i);
         cyc(1);
         chk(lamp_driver_latch & 8'h67,
             8'(1 << pos[i]));
      end
      cpu_idle_test = 1'b0;
      host_cmd_download = 1'b1;
      cyc(1);
      host_cmd_download = 1'b0;
      chk(lamp_driver_latch & 8'h18, 8'h18);
      host_cmd_start = 1'b1;
      cyc(1);
      host_cmd_start = 1'b0;
      chk(lamp_driver_latch & 8'h18, 8'h00);
   endtask
   task automatic t_idle;
      idle_fail = 1'b1;
      idle_err_code = 8'h5a;
      cyc(1);
      idle_fail = 1'b0;
      chk(diagnostic_code_word, 8'h5a);
      ack();
      step_wr = 1'b1;
      step_num = 8'h33;
      cyc(1);
      step_wr = 1'b0;
      chk(diagnostic_code_word, 8'h5a);
   endtask
   task automatic t_mau;
      mau_power_set = 1'b1;
      cyc(1);
      mau_power_set = 1'b0;
      cyc(2);
      chk(8'({mau_power_on, mau_power_ok, mau_power_lamp}), 8'h07);
      for (int k = 0; k < 2; k++) begin
         mau_power_trip = 1'b1;
         cyc(1);
         mau_power_trip = 1'b0;
         cyc(3);
         chk(8'({mau_power_on, mau_fault}), k ? 8'h01 : 8'h02);
      end
   endtask
   task automatic t_dataout;
      int   n  = 0;
      logic bd = 1'b0;
      logic hb = 1'b0;
      for (int i = 0; i < 40; i++) begin
         tx_enable = (i < 10);
         cyc(1);
         n += int'(data_out_lamp_l);
         bd |= collision_lamp_e | carrier_lamp_e;
         hb |= collision_lamp_l;
      end
      chk(8'(n), 8'h0a);
      chk(8'({data_out_lamp_e, bd, hb}), 8'h05);
      cyc(HOLD - 20);
      chk(8'(data_out_lamp_e), 8'h00);
   endtask
   task automatic t_burst(input logic coll);
      {coll_req, data_req} = {coll, !coll};
      cyc(6);
      {coll_req, data_req} = 2'h0;
      cyc(10);
      chk(8'({carrier_lamp_e, carrier_lamp_l, collision_lamp_e,
              collision_lamp_l}), coll ? 8'h0f : 8'h0c);
      cyc(30);
      chk(8'(collision_lamp_l), 8'h00);
      cyc(HOLD);
   endtask
   task automatic t_loop;
      loopback_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         tx_data = 1'(4'hb >> i);
         cyc(1);
         chk(8'(rx_data), 8'(tx_data));
      end
      // loopback off: the quiet receive line must show again
      loopback_en = 1'b0;
      cyc(1);
      chk(8'(rx_data), 8'h00);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      cyc(16);
      rst_b = 1'b1;
      cyc(1);
      chk(lamp_driver_latch, 8'hff);
      chk(8'({host_irq, command_wait_phase, mau_power_lamp,
              data_out_lamp_e, carrier_lamp_e}), 8'h00);
      for (int i = 0; i < 4; i++) t_self(i);
      t_cpu();
      t_idle();
      t_mau();
      t_dataout();
      t_burst(1'b0);
      t_burst(1'b1);
      t_loop();
      final_report();
   end
endmodule // tb_actind_top
